// ==== design/hseq_sync.sv ====
// Two-stage synchroniser with level and edge outputs for the sensor inputs
`timescale 1ns/1ps
`default_nettype none
module hseq_sync
    import hseq_pkg::*;
#(
    parameter int W = HSEQ_IN_W
) (
    input wire logic mclk, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic [W-1:0] async_in, // Raw pin levels
    output logic [W-1:0] level, // Synchronised level
    output logic [W-1:0] rise, // One-cycle rising edge
    output logic [W-1:0] fall // One-cycle falling edge
);
    initial begin
        if (W < 1) begin
            $error("hseq_sync: W must be at least 1");
        end
    end

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// ==== design/hseq_top.sv ====
// Homing sequencer for return-to-origin methods 22 to 35
//
// What this block does
// - Method 22, home off: fast negative, slow positive off, slow negative to rise.
// - Method 22, home on: slow positive to fall, then slow negative to rise.
// - Method 23 negative side: fast positive, at rise slow negative to fall.
// - Method 23 positive side: forward limit reverses fast, then clear, then fall.
// - Methods 23 and 30, home on: slow negative, stop at fall.
// - Method 24 negative side: fast positive, slow negative off, slow positive to rise.
// - Method 24 positive side: limit reverses fast, after fall slow positive to rise.
// - Method 24, home on: slow negative to fall, slow positive to rise.
// - Method 25 negative side: fast positive to fall, slow negative to rise.
// - Method 25 positive side: limit reverses, then clear, slow negative to rise.
// - Method 26 negative side: fast positive, slow negative off, slow positive to fall.
// - Method 26 positive side: limit reverses fast, at rise slow positive to fall.
// - Method 27: fast negative, slow positive to fall; home on: slow positive to fall.
// - Method 28 positive side: fast negative, slow positive off, slow negative to rise.
// - Method 28 negative side: reverse limit reverses fast, after fall slow negative.
// - Method 28, home on: slow positive to fall, slow negative to rise.
// - Method 29, home on: slow negative to fall, slow positive to rise.
// - Method 30 positive side: fast negative, slow positive off, slow negative to fall.
// - Methods 31 and 32 are reserved and start no motion.
// - Method 33: slow negative, stop at first index pulse.
// - Method 34: slow positive, stop at first index pulse.
// - Method 35: no motion, present position becomes origin.
`timescale 1ns/1ps
`default_nettype none
module hseq_top
    import hseq_pkg::*;
#(
    parameter int POS_W = HSEQ_POS_W
) (
    input wire logic mclk, // System clock, 125 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic home_switch_input, // Home sensor pin
    input wire logic forward_limit_input, // Forward limit pin
    input wire logic reverse_limit_input, // Reverse limit pin
    input wire logic index_input, // Encoder index pin
    input wire logic start, // Start pulse, same clock
    input wire logic [5:0] method, // Homing method, read at start
    input wire logic abort, // Stop without origin
    input wire logic speed_zero, // Profile generator at rest
    input wire logic [POS_W-1:0] pos_fb, // Present position
    output hseq_motion_s motion_ff, // Commanded motion
    output logic busy_ff, // Sequence in progress
    output logic done_ff, // Homing complete pulse
    output logic err_ff, // Refused or failed pulse
    output logic origin_set_ff, // Origin latched pulse
    output logic [POS_W-1:0] origin_pos_ff // Latched origin position
);
    initial begin
        if (POS_W < 1) begin
            $error("hseq_top: POS_W must be at least 1");
        end
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MOVE,
        ST_DECEL
    } hseq_state_e;

    hseq_state_e state_ff;
    logic [5:0] method_ff;
    logic act_ff;
    logic alt_ff;
    logic [1:0] idx_ff;
    logic final_ff;
    logic fail_ff;

    logic [HSEQ_IN_W-1:0] in_lvl;
    logic [HSEQ_IN_W-1:0] in_rise;
    logic [HSEQ_IN_W-1:0] in_fall;
    logic [HSEQ_IN_W-1:0] pins;

    hseq_step_s cur_step;
    hseq_step_s first_step;
    logic evt_hit;
    logic lim_branch;
    logic lim_bad;
    logic stop_now;

    function automatic hseq_step_s mk(input logic d, input logic f, input hseq_evt_e e,
                                      input logic l, input hseq_lim_e lim);
        hseq_step_s s;
        s.ok = 1'h1;
        s.dir_pos = d;
        s.fast = f;
        s.evt = e;
        s.last = l;
        s.lim = lim;
        return s;
    endfunction

    // Step table: method, home level at start, limit branch taken, step number
    function automatic hseq_step_s step_of(input logic [5:0] m, input logic a,
                                           input logic alt, input logic [1:0] i);
        hseq_step_s s;
        logic [2:0] k;
        s = '0;
        k = {alt, i};
        case (m)
            HSEQ_M22: begin
                if (a) begin
                    case (i)
                        2'h0: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_MORE, HSEQ_LIM_NONE);
                        2'h1: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end else begin
                    case (k)
                        3'h0: s = mk(HSEQ_NEG, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h1: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HI, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h2: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            HSEQ_M23: begin
                if (a) begin
                    if (i == 2'h0) begin
                        s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                    end
                end else begin
                    case (k)
                        3'h0: s = mk(HSEQ_POS, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_FWD);
                        3'h1: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                        3'h4: s = mk(HSEQ_NEG, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h5: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HI, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h6: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            HSEQ_M24: begin
                if (a) begin
                    case (i)
                        2'h0: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_MORE, HSEQ_LIM_NONE);
                        2'h1: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end else begin
                    case (k)
                        3'h0: s = mk(HSEQ_POS, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_FWD);
                        3'h1: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HI, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h2: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        3'h4: s = mk(HSEQ_NEG, HSEQ_FAST, HSEQ_EV_HF, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h5: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            HSEQ_M25: begin
                if (a) begin
                    case (i)
                        2'h0: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_MORE, HSEQ_LIM_NONE);
                        2'h1: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end else begin
                    case (k)
                        3'h0: s = mk(HSEQ_POS, HSEQ_FAST, HSEQ_EV_HF, HSEQ_MORE, HSEQ_LIM_FWD);
                        3'h1: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        3'h4: s = mk(HSEQ_NEG, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h5: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HI, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h6: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            HSEQ_M26: begin
                if (a) begin
                    if (i == 2'h0) begin
                        s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                    end
                end else begin
                    case (k)
                        3'h0: s = mk(HSEQ_POS, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_FWD);
                        3'h1: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HI, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h2: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                        3'h4: s = mk(HSEQ_NEG, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h5: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            HSEQ_M27: begin
                if (a) begin
                    if (i == 2'h0) begin
                        s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                    end
                end else begin
                    case (k)
                        3'h0: s = mk(HSEQ_NEG, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h1: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            HSEQ_M28: begin
                if (a) begin
                    case (i)
                        2'h0: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_MORE, HSEQ_LIM_NONE);
                        2'h1: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end else begin
                    case (k)
                        3'h0: s = mk(HSEQ_NEG, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_REV);
                        3'h1: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HI, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h2: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        3'h4: s = mk(HSEQ_POS, HSEQ_FAST, HSEQ_EV_HF, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h5: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            // method 29, only the start with home on is defined
            HSEQ_M29: begin
                if (a) begin
                    case (i)
                        2'h0: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_MORE, HSEQ_LIM_NONE);
                        2'h1: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HR, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            HSEQ_M30: begin
                if (a) begin
                    if (i == 2'h0) begin
                        s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                    end
                end else begin
                    case (k)
                        3'h0: s = mk(HSEQ_NEG, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_REV);
                        3'h1: s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_HI, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h2: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                        3'h4: s = mk(HSEQ_POS, HSEQ_FAST, HSEQ_EV_HR, HSEQ_MORE, HSEQ_LIM_NONE);
                        3'h5: s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_HF, HSEQ_LAST, HSEQ_LIM_NONE);
                        default: s = '0;
                    endcase
                end
            end
            HSEQ_M33: begin
                if (k == 3'h0) begin
                    s = mk(HSEQ_NEG, HSEQ_SLOW, HSEQ_EV_IDX, HSEQ_LAST, HSEQ_LIM_NONE);
                end
            end
            HSEQ_M34: begin
                if (k == 3'h0) begin
                    s = mk(HSEQ_POS, HSEQ_SLOW, HSEQ_EV_IDX, HSEQ_LAST, HSEQ_LIM_NONE);
                end
            end
            // reserved and unknown codes yield no step
            default: s = '0;
        endcase
        return s;
    endfunction

    assign pins = {index_input, reverse_limit_input, forward_limit_input, home_switch_input};

    hseq_sync #(
        .W(HSEQ_IN_W)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in(pins),
        .level(in_lvl),
        .rise(in_rise),
        .fall(in_fall)
    );

    assign cur_step = step_of(method_ff, act_ff, alt_ff, idx_ff);
    assign first_step = step_of(method, in_lvl[HSEQ_IN_HOME], 1'h0, 2'h0);

    always_comb begin
        case (cur_step.evt)
            HSEQ_EV_HR: evt_hit = in_rise[HSEQ_IN_HOME];
            HSEQ_EV_HF: evt_hit = in_fall[HSEQ_IN_HOME];
            HSEQ_EV_HI: evt_hit = ~in_lvl[HSEQ_IN_HOME];
            default: evt_hit = in_rise[HSEQ_IN_IDX];
        endcase
    end

    // Limit met while travelling toward it: branch if the step allows, else fail
    assign lim_branch = (cur_step.lim == HSEQ_LIM_FWD && cur_step.dir_pos
                         && in_rise[HSEQ_IN_FWD])
                        || (cur_step.lim == HSEQ_LIM_REV && !cur_step.dir_pos
                            && in_rise[HSEQ_IN_REV]);
    assign lim_bad = !lim_branch && ((cur_step.dir_pos && in_rise[HSEQ_IN_FWD])
                                     || (!cur_step.dir_pos && in_rise[HSEQ_IN_REV]));
    assign stop_now = abort || lim_branch || lim_bad || evt_hit;

    // Sequencer state and step position
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            method_ff <= '0;
            act_ff <= 1'h0;
            alt_ff <= 1'h0;
            idx_ff <= '0;
            final_ff <= 1'h0;
            fail_ff <= 1'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (start && method != HSEQ_M35 && first_step.ok) begin
                        state_ff <= ST_MOVE;
                        method_ff <= method;
                        act_ff <= in_lvl[HSEQ_IN_HOME];
                        alt_ff <= 1'h0;
                        idx_ff <= '0;
                        final_ff <= 1'h0;
                        fail_ff <= 1'h0;
                    end
                end
                ST_MOVE: begin
                    // every exit passes through the stop state
                    if (stop_now) begin
                        state_ff <= ST_DECEL;
                    end
                    if (abort || lim_bad) begin
                        fail_ff <= 1'h1;
                    end else if (lim_branch) begin
                        alt_ff <= 1'h1;
                        idx_ff <= '0;
                    end else if (evt_hit) begin
                        if (cur_step.last) begin
                            final_ff <= 1'h1;
                        end else begin
                            idx_ff <= idx_ff + 2'h1;
                        end
                    end
                end
                ST_DECEL: begin
                    // wait for rest before next motion
                    if (speed_zero) begin
                        state_ff <= (final_ff || fail_ff) ? ST_IDLE : ST_MOVE;
                    end
                end
            endcase
        end
    end

    // Motion command follows the active step and drops the cycle after an exit is seen
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            motion_ff <= '0;
        end else if (state_ff == ST_MOVE && !stop_now) begin
            motion_ff <= {1'h1, cur_step.dir_pos, cur_step.fast};
        end else begin
            motion_ff <= '0;
        end
    end

    // Completion, origin latch and error indications
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            busy_ff <= 1'h0;
            done_ff <= 1'h0;
            err_ff <= 1'h0;
            origin_set_ff <= 1'h0;
            origin_pos_ff <= '0;
        end else begin
            done_ff <= 1'h0;
            err_ff <= 1'h0;
            origin_set_ff <= 1'h0;
            if (state_ff == ST_IDLE && start) begin
                if (method == HSEQ_M35) begin
                    origin_pos_ff <= pos_fb;
                    origin_set_ff <= 1'h1;
                    done_ff <= 1'h1;
                end else if (!first_step.ok) begin
                    err_ff <= 1'h1;
                end else begin
                    busy_ff <= 1'h1;
                end
            end
            if (state_ff == ST_MOVE && !abort && lim_bad) begin
                err_ff <= 1'h1;
            end
            if (state_ff == ST_DECEL && speed_zero && (final_ff || fail_ff)) begin
                busy_ff <= 1'h0;
                if (final_ff && !fail_ff) begin
                    origin_pos_ff <= pos_fb;
                    origin_set_ff <= 1'h1;
                    done_ff <= 1'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== inc/hseq_pkg.sv ====
// Constants, method codes and carrier types of the homing sequencer
package hseq_pkg;

    // Homing method codes handled by this block
    localparam logic [5:0] HSEQ_M22 = 6'h16;
    localparam logic [5:0] HSEQ_M23 = 6'h17;
    localparam logic [5:0] HSEQ_M24 = 6'h18;
    localparam logic [5:0] HSEQ_M25 = 6'h19;
    localparam logic [5:0] HSEQ_M26 = 6'h1A;
    localparam logic [5:0] HSEQ_M27 = 6'h1B;
    localparam logic [5:0] HSEQ_M28 = 6'h1C;
    localparam logic [5:0] HSEQ_M29 = 6'h1D;
    localparam logic [5:0] HSEQ_M30 = 6'h1E;
    localparam logic [5:0] HSEQ_M31 = 6'h1F;
    localparam logic [5:0] HSEQ_M32 = 6'h20;
    localparam logic [5:0] HSEQ_M33 = 6'h21;
    localparam logic [5:0] HSEQ_M34 = 6'h22;
    localparam logic [5:0] HSEQ_M35 = 6'h23;

    // Bit positions of the sensor inputs in the synchroniser vector
    localparam int HSEQ_IN_HOME = 0;
    localparam int HSEQ_IN_FWD = 1;
    localparam int HSEQ_IN_REV = 2;
    localparam int HSEQ_IN_IDX = 3;
    localparam int HSEQ_IN_W = 4;

    // Synchroniser depth and default position width
    localparam int HSEQ_SYNC_STAGES = 2;
    localparam int HSEQ_POS_W = 32;

    // Direction and speed encodings of a motion step
    localparam logic HSEQ_POS = 1'h1;
    localparam logic HSEQ_NEG = 1'h0;
    localparam logic HSEQ_FAST = 1'h1;
    localparam logic HSEQ_SLOW = 1'h0;
    localparam logic HSEQ_LAST = 1'h1;
    localparam logic HSEQ_MORE = 1'h0;

    // Event that ends a motion step
    typedef enum logic [1:0] {
        HSEQ_EV_HR,
        HSEQ_EV_HF,
        HSEQ_EV_HI,
        HSEQ_EV_IDX
    } hseq_evt_e;

    // Limit switch that diverts a fast search step into its second branch
    typedef enum logic [1:0] {
        HSEQ_LIM_NONE,
        HSEQ_LIM_FWD,
        HSEQ_LIM_REV
    } hseq_lim_e;

    typedef struct packed {
        logic ok;
        logic dir_pos;
        logic fast;
        hseq_evt_e evt;
        logic last;
        hseq_lim_e lim;
    } hseq_step_s;

    typedef struct packed {
        logic run;
        logic dir_pos;
        logic fast;
    } hseq_motion_s;

endpackage

// ==== tb/hseq_far.sv ====
// Motion stage model: position, sensors, index and rest flag
`timescale 1ns/1ps
`default_nettype none
module hseq_far
    import hseq_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic ld, // Load position
    input wire logic [11:0] ld_v, // Load value
    input wire logic [3:0] dly, // Rest delay
    input wire hseq_motion_s mo, // Motion
    output logic [11:0] pos, // Position
    output logic [3:0] pins, // Index, reverse, forward, home
    output logic rest // At rest
);
    logic [3:0] cnt = 4'h0;
    always_ff @(posedge mclk) begin
        cnt <= mo.run ? 4'h0 : cnt + {3'h0, cnt != dly};
        pos <= ld ? ld_v : pos + (mo.run ? (mo.dir_pos ? 12'h1 : 12'hFFF) << {mo.fast, 1'h0} : 12'h0);
    end
    assign rest = !mo.run && cnt == dly;
    assign pins = {pos[5:0] == 6'h0, pos <= 12'h14, pos >= 12'h258, pos >= 12'hC8 && pos <= 12'h104};
endmodule
`default_nettype wire

// ==== tb/hseq_top_asserts.sv ====
// Port checker for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module hseq_chk
    import hseq_pkg::*;
#(
    parameter int POS_W = HSEQ_POS_W
) (
    input wire logic mclk, // Clock
    input wire logic rst_b, // Reset
    input wire logic start, // Start
    input wire logic [5:0] method, // Method
    input wire logic [POS_W-1:0] pos_fb, // Position
    input wire hseq_motion_s motion_ff, // Motion
    input wire logic busy_ff, // Busy
    input wire logic done_ff, // Done
    input wire logic err_ff, // Refused
    input wire logic origin_set_ff, // Origin pulse
    input wire logic [POS_W-1:0] origin_pos_ff // Origin
);
    logic go;
    assign go = start && !busy_ff;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    done_org_a: assert property (done_ff |-> origin_set_ff && !busy_ff)
        else $error("done without origin");
    org_pos_a: assert property (origin_set_ff |-> origin_pos_ff == $past(pos_fb))
        else $error("origin not latched");
    idle_stop_a: assert property (!busy_ff |-> !motion_ff.run)
        else $error("motion while idle");
    step_hold_a: assert property (motion_ff.run && $past(motion_ff.run) |-> $stable(motion_ff))
        else $error("motion changed without stop");
    rsvd_a: assert property (go && (method == HSEQ_M31 || method == HSEQ_M32) |=> err_ff && !busy_ff)
        else $error("reserved method accepted");
    idx_neg_a: assert property (go && method == HSEQ_M33 |=> ##1 motion_ff == 3'h4)
        else $error("index search not slow negative");
    idx_pos_a: assert property (go && method == HSEQ_M34 |=> ##1 motion_ff == 3'h6)
        else $error("index search not slow positive");
    here_a: assert property (go && method == HSEQ_M35 |=> done_ff && origin_pos_ff == $past(pos_fb))
        else $error("present position not taken");
    cover property (done_ff);
    cover property (err_ff);
    cover property (motion_ff.run && motion_ff.fast);
endmodule
bind hseq_top hseq_chk #(.POS_W(POS_W)) u_chk (.mclk(mclk), .rst_b(rst_b), .start(start),
    .method(method), .pos_fb(pos_fb), .motion_ff(motion_ff), .busy_ff(busy_ff),
    .done_ff(done_ff), .err_ff(err_ff), .origin_set_ff(origin_set_ff),
    .origin_pos_ff(origin_pos_ff));
`default_nettype wire

// ==== tb/tb.sv ====
// Bench for the homing sequencer against a motion stage model
`timescale 1ns/1ps
`default_nettype none
module tb import hseq_pkg::*;;
    localparam logic [11:0] A = 12'h64, B = 12'h190, C = 12'hE6, L = 12'hC8, H = 12'h104;
    logic mclk = 1'b0, rst_b = 1'b0, start = 1'b0, ld = 1'b1, rest, busy, done, err;
    logic [5:0] method = 6'h0;
    logic [3:0] dly = 4'h0, pins;
    logic [11:0] ld_v = 12'h64, pos;
    logic [31:0] opos;
    hseq_motion_s mo;
    int err_total = 0, samples_checked = 0;
    hseq_far far (.mclk(mclk), .ld(ld), .ld_v(ld_v), .dly(dly), .mo(mo), .pos(pos),
        .pins(pins), .rest(rest));
    hseq_top DUT (.mclk(mclk), .rst_b(rst_b), .home_switch_input(pins[0]),
        .forward_limit_input(pins[1]), .reverse_limit_input(pins[2]), .index_input(pins[3]),
        .start(start), .method(method), .abort(1'b0), .speed_zero(rest), .pos_fb({20'h0, pos}),
        .motion_ff(mo), .busy_ff(busy), .done_ff(done), .err_ff(err), .origin_set_ff(),
        .origin_pos_ff(opos));
    initial forever #4 mclk = ~mclk;
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input logic [11:0] got, input logic [11:0] exp);
        logic ok;
        ok = got + 12'h8 >= exp && got <= exp + 12'h8;
        samples_checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Park the stage, let the sensors settle, then pulse start
    task automatic kick(input logic [5:0] m, input logic [11:0] p);
        @(negedge mclk);
        ld = 1'b1;
        ld_v = p;
        @(negedge mclk);
        ld = 1'b0;
        repeat (4) @(negedge mclk);
        start = 1'b1;
        method = m;
        @(negedge mclk);
        start = 1'b0;
    endtask
    task automatic run(input logic [5:0] m, input logic [11:0] p, input logic [11:0] e);
        int n;
        kick(m, p);
        for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge mclk);
        if (done !== 1'b1) begin
            err_total++;
            close_out();
        end else begin
            chk_near(opos[11:0], e);
            chk(opos, {20'h0, pos});
        end
    endtask
    task automatic refuse(input logic [5:0] m);
        kick(m, A);
        chk({30'h0, err, busy}, 32'h2);
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        run(HSEQ_M22, B, H);
        run(HSEQ_M22, C, H);
        run(HSEQ_M23, A, L);
        run(HSEQ_M23, B, L);
        run(HSEQ_M23, C, L);
        run(HSEQ_M30, C, L);
        dly = 4'h5;
        run(HSEQ_M24, A, L);
        run(HSEQ_M24, B, L);
        run(HSEQ_M24, C, L);
        run(HSEQ_M25, A, H);
        run(HSEQ_M25, B, H);
        run(HSEQ_M26, A, H);
        run(HSEQ_M26, B, H);
        run(HSEQ_M27, B, H);
        run(HSEQ_M27, C, H);
        dly = 4'h0;
        run(HSEQ_M28, B, H);
        run(HSEQ_M28, A, H);
        run(HSEQ_M28, C, H);
        run(HSEQ_M29, C, L);
        run(HSEQ_M30, B, L);
        refuse(HSEQ_M31);
        refuse(HSEQ_M32);
        run(HSEQ_M33, A, 12'h40);
        run(HSEQ_M34, A, 12'h80);
        run(HSEQ_M35, A, A);
        close_out();
    end
endmodule
`default_nettype wire
